// File: reclk_pkg.sv
// shared types and constants for the reclocker output control
package reclk_pkg;

    localparam int REF_HZ = 27000000;
    localparam int SYS_HZ = 200000000;
    // one reference period in system cycles, rounded down
    localparam int REF_PERIOD_CYC = SYS_HZ / REF_HZ;
    // lock loss after an input change, longest time in microseconds
    localparam int LOCK_DROP_US = 1000;
    localparam int LOCK_DROP_CYC = LOCK_DROP_US * (SYS_HZ / 1000000);
    // acquisition window in microseconds
    localparam int ACQ_US = 15000;
    localparam int ACQ_CYC = ACQ_US * (SYS_HZ / 1000000);
    localparam int CNT_W = 22;

    localparam logic [1:0] SEL_IN0 = 2'h0;
    localparam logic [1:0] SEL_IN1 = 2'h1;
    localparam logic [1:0] SEL_IN2 = 2'h2;
    localparam logic [1:0] SEL_IN3 = 2'h3;
    localparam logic SEL_RESET = 1'h0;
    localparam logic CLOCK_MODE_RESET = 1'h0;

    // measured rate classes from the rate detector
    typedef enum logic [2:0] {
        RATE_NONE,
        RATE_SD_270,
        RATE_HD_1483,
        RATE_HD_1485,
        RATE_3G_2967,
        RATE_3G_2970,
        RATE_UNSUPPORTED,
        RATE_HARMONIC
    } rate_class_type;

    typedef struct packed {
        logic p;
        logic n;
    } diff_pair_type;

    typedef struct packed {
        logic [1:0] select;
        logic clock_mode;
        logic force_bypass;
        logic mute_n;
    } ctrl_type;

    typedef struct packed {
        logic locked;
        logic bypass;
        logic sd_rate;
        logic aux_clock_valid;
    } status_type;

    // reset: both pairs muted, status shows bypass only
    localparam diff_pair_type PAIR_MUTED = 2'h1;
    localparam status_type STATUS_RESET = 4'h4;

endpackage : reclk_pkg

// File: retime_stage.sv
// one-bit retiming flop pair producing retimed data and its clock phase
`timescale 1ns/1ps
module retime_stage
    import reclk_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // stream
    input wire logic data_in,
    output logic data_out,
    output logic clock_out
);

    typedef struct packed {
        logic data;
        logic phase;
    } retime_state_type;

    retime_state_type state;
    retime_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.data = data_in;
        // clock toggles on the same edge that launches data, so it rises every second bit
        next_state.phase = ~state.phase;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign data_out = state.data;
    assign clock_out = state.phase;

endmodule : retime_stage

// File: sdi_reclocker_output_control.sv
// input selection, retime/bypass choice and output muting of the reclocker
`timescale 1ns/1ps
module sdi_reclocker_output_control
    import reclk_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // serial inputs, already equalized
    input wire logic [3:0] serial_inputs,
    // control pins
    input wire logic input_select_lsb,
    input wire logic input_select_msb,
    input wire logic aux_clock_mode_select,
    input wire logic force_bypass,
    input wire logic output_mute_n,
    // rate detector result for the selected input
    input wire rate_class_type detected_rate,
    input wire logic asi_stream,
    // outputs
    output diff_pair_type primary_serial_output,
    output diff_pair_type aux_serial_output,
    output status_type status
);

    typedef enum logic [1:0] {
        ST_UNLOCKED,
        ST_ACQUIRE,
        ST_LOCKED
    } lock_state_type;

    typedef struct packed {
        lock_state_type lock;
        logic [CNT_W-1:0] count;
        logic [1:0] select;
        rate_class_type rate;
        diff_pair_type primary;
        diff_pair_type aux;
        status_type stat;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;

    logic [1:0] select_code;
    logic chosen_bit;
    logic retimed_bit;
    logic retimed_clock;
    logic supported;
    logic bypass_now;
    logic aux_is_clock;
    logic out_bit;
    logic aux_bit;

    // supported rate classes; asi is carried at the sd rate
    function automatic logic rate_supported(input rate_class_type r);
        rate_supported = (r == RATE_SD_270) || (r == RATE_HD_1483) || (r == RATE_HD_1485)
            || (r == RATE_3G_2967) || (r == RATE_3G_2970);
    endfunction : rate_supported

    function automatic diff_pair_type drive_pair(input logic bit_val, input logic mute);
        drive_pair.p = mute ? 1'h0 : bit_val;
        drive_pair.n = mute ? 1'h1 : ~bit_val;
    endfunction : drive_pair

    // open pins read as low through the pulls, so code 00 and data mode are the defaults
    assign select_code = {input_select_msb, input_select_lsb};
    // the equalizers are fixed, no configuration path exists here
    assign chosen_bit = serial_inputs[select_code];

    retime_stage u_retime (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .data_in(chosen_bit),
        .data_out(retimed_bit),
        .clock_out(retimed_clock)
    );

    // harmonics and unsupported rates never count as supported
    assign supported = rate_supported(detected_rate) && !(asi_stream
        && (detected_rate != RATE_SD_270));
    assign bypass_now = force_bypass || (state.lock != ST_LOCKED);
    assign aux_is_clock = aux_clock_mode_select;

    // bypass passes the chosen input straight through, unretimed
    assign out_bit = bypass_now ? chosen_bit : retimed_bit;
    // clock is the retimer phase, which toggles every cycle whatever the rate
    assign aux_bit = aux_is_clock ? retimed_clock : out_bit;

    always_comb begin
        next_state = state;
        next_state.select = select_code;
        next_state.rate = detected_rate;
        unique case (state.lock)
            ST_UNLOCKED: begin
                next_state.count = '0;
                if (!force_bypass && supported) begin
                    next_state.lock = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE: begin
                next_state.count = state.count + CNT_W'(1);
                if (force_bypass || !supported || detected_rate != state.rate
                        || select_code != state.select) begin
                    next_state.lock = ST_UNLOCKED;
                end else if (state.count >= CNT_W'(REF_PERIOD_CYC)) begin
                    next_state.lock = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                next_state.count = '0;
                // input change or rate change drops lock at once
                if (force_bypass || !supported || detected_rate != state.rate
                        || select_code != state.select) begin
                    next_state.lock = ST_UNLOCKED;
                end
            end
        endcase
        // mute overrides bypass and every mode
        next_state.primary = drive_pair(out_bit, !output_mute_n);
        next_state.aux = drive_pair(aux_bit,
            !output_mute_n || (aux_is_clock && bypass_now));
        next_state.stat.locked = (next_state.lock == ST_LOCKED) && !force_bypass;
        next_state.stat.bypass = force_bypass || (next_state.lock != ST_LOCKED);
        // sd flag only meaningful while locked, reads hd otherwise
        next_state.stat.sd_rate = (next_state.lock == ST_LOCKED)
            && (detected_rate == RATE_SD_270);
        // far side must ignore aux clock when this is low
        next_state.stat.aux_clock_valid = aux_is_clock && !next_state.stat.bypass
            && output_mute_n;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state.lock <= ST_UNLOCKED;
            state.count <= '0;
            state.select <= {2{SEL_RESET}};
            state.rate <= RATE_NONE;
            state.primary <= PAIR_MUTED;
            state.aux <= PAIR_MUTED;
            state.stat <= STATUS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign primary_serial_output = state.primary;
    assign aux_serial_output = state.aux;
    assign status = state.stat;

endmodule : sdi_reclocker_output_control

// File: cable_eq_model.sv
// upstream equalizer model: four pseudo-random equalized lanes
`timescale 1ns/1ps
module cable_eq_model (
    // clock
    input wire logic sys_clk,
    // equalized lanes
    output logic [3:0] lanes = 4'h0
);
    logic [15:0] lfsr = 16'hACE1;
    // lanes are far-apart shifts of one sequence, so a wrong select cannot alias
    always @(negedge sys_clk) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        lanes <= {lfsr[15], lfsr[10], lfsr[5], lfsr[0]};
    end
endmodule : cable_eq_model

// File: reclk_sva.sv
// concurrent checks on the reclocker output control pins
`timescale 1ns/1ps
module reclk_sva
    import reclk_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // in
    input wire logic input_select_lsb,
    input wire logic input_select_msb,
    input wire logic aux_clock_mode_select,
    input wire logic force_bypass,
    input wire logic output_mute_n,
    input wire rate_class_type detected_rate,
    // out
    input wire diff_pair_type primary_serial_output,
    input wire diff_pair_type aux_serial_output,
    input wire status_type status
);
    wire diff_pair_type pri = primary_serial_output;
    wire diff_pair_type aux = aux_serial_output;
    wire good = detected_rate inside {[RATE_SD_270:RATE_3G_2970]};
    wire run = status.locked && output_mute_n;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_steady;
        good && !force_bypass && $stable({detected_rate, input_select_msb, input_select_lsb});
    endsequence
    property p_lock; s_steady [*8] |-> ##[1:6] status.locked; endproperty
    a_lock: assert property (p_lock) else $error("lock late");
    property p_bad; detected_rate > RATE_3G_2970 |=> !status.locked && status.bypass; endproperty
    a_bad: assert property (p_bad) else $error("bad rate locked");
    property p_force; force_bypass |=> !status.locked && status.bypass; endproperty
    a_force: assert property (p_force) else $error("bypass ignored");
    property p_mute; !output_mute_n |=> pri == 2'h1 && aux == 2'h1; endproperty
    a_mute: assert property (p_mute) else $error("mute ignored");
    property p_legs; pri.p != pri.n && aux.p != aux.n; endproperty
    a_legs: assert property (p_legs) else $error("legs equal");
    property p_clkbyp; aux_clock_mode_select && force_bypass |=> aux == 2'h1; endproperty
    a_clkbyp: assert property (p_clkbyp) else $error("clock not muted");
    property p_clk; (run && aux_clock_mode_select) [*3] |-> aux.p != $past(aux.p); endproperty
    a_clk: assert property (p_clk) else $error("clock stuck");
    property p_copy; (run && !aux_clock_mode_select) [*3] |-> aux == pri; endproperty
    a_copy: assert property (p_copy) else $error("aux not data");
endmodule : reclk_sva
bind sdi_reclocker_output_control reclk_sva i_reclk_sva (.sys_clk(sys_clk), .resetn(resetn),
    .input_select_lsb(input_select_lsb), .input_select_msb(input_select_msb),
    .aux_clock_mode_select(aux_clock_mode_select), .force_bypass(force_bypass),
    .output_mute_n(output_mute_n), .detected_rate(detected_rate),
    .primary_serial_output(primary_serial_output), .aux_serial_output(aux_serial_output),
    .status(status));

// File: tb_top.sv
// self-checking bench for the reclocker output control
`timescale 1ns/1ps
module tb_top;
    import reclk_pkg::*;
    logic sys_clk = 0;
    logic resetn = 0;
    logic [1:0] sel = 0;
    logic cm = 0;
    logic byp = 0;
    logic mn = 1;
    logic asi = 0;
    rate_class_type rate = RATE_NONE;
    logic [3:0] lanes;
    diff_pair_type pri;
    diff_pair_type aux;
    status_type st;
    int fails = 0;
    int num_checks = 0;
    logic [31:0] rng = 32'h1198E;
    logic qi[$];
    logic qo[$];
    cable_eq_model i_cable_eq_model (.sys_clk(sys_clk), .lanes(lanes));
    sdi_reclocker_output_control i_sdi_reclocker_output_control (.sys_clk(sys_clk),
        .resetn(resetn), .serial_inputs(lanes), .input_select_lsb(sel[0]),
        .input_select_msb(sel[1]), .aux_clock_mode_select(cm), .force_bypass(byp),
        .output_mute_n(mn), .detected_rate(rate), .asi_stream(asi),
        .primary_serial_output(pri), .aux_serial_output(aux), .status(st));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(logic [3:0] seen, logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic tick(int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic wait_lock;
        tick(1);
        for (int n = 0; st.locked !== 1'b1; n++) begin
            if (n == 40) begin
                fails++;
                test_done();
            end
            tick(1);
        end
    endtask : wait_lock
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    // bypass passes the pin through one flop, retiming adds one more
    function automatic logic dly_ok(int d);
        logic ok;
        ok = 1;
        for (int i = 4; i < 24; i++) ok &= qo[i] === qi[i - d];
        return ok;
    endfunction : dly_ok
    initial begin
        tick(3);
        check(st, 4'h4);
        resetn = 1;
        for (int r = 0; r < 8; r++) begin
            rate = rate_class_type'(r);
            cm = r[0];
            tick(20);
            check(4'({st.locked, st.bypass}), r inside {[1:5]} ? 4'h2 : 4'h1);
            if (r > 5 && cm) check(4'(aux), 4'h1);
        end
        rate = RATE_3G_2970;
        for (int i = 0; i < 8; i++) begin
            sel = i[1:0];
            byp = i[2];
            cm = 0;
            if (!byp) wait_lock();
            qi.delete();
            qo.delete();
            repeat (24) begin
                tick(1);
                qi.push_back(lanes[sel]);
                qo.push_back(pri.p);
                check(4'(aux), 4'(pri));
            end
            check(4'(dly_ok(byp ? 0 : 1)), 4'h1);
            check(4'(st.locked), 4'(!byp));
            check(4'(st.sd_rate), 4'h0);
        end
        byp = 0;
        asi = 1;
        rate = RATE_SD_270;
        wait_lock();
        check(4'(st.locked), 4'h1);
        check(4'(st.sd_rate), 4'h1);
        cm = 1;
        tick(2);
        check(4'(st.aux_clock_valid), 4'h1);
        byp = 1;
        tick(1);
        check(4'(st.aux_clock_valid), 4'h0);
        check(4'(aux), 4'h1);
        byp = 0;
        repeat (200) begin
            rng = xs(rng);
            mn = rng[0] | rng[1];
            cm = rng[2];
            sel = rng[4:3];
            byp = rng[5];
            tick(1);
            if (!mn) check(4'({pri, aux}), 4'h5);
            if (mn && cm && byp) check(4'(aux), 4'h1);
            if (byp) check(4'(st.locked), 4'h0);
        end
        test_done();
    end
endmodule : tb_top
